// *** rtl/adm_consts.svh ***
// Offsets, field positions, reset values and limits of the mode-control register bank.
// Assumes it is included by bare name from files that need these numbers.
`ifndef ADM_CONSTS_SVH
`define ADM_CONSTS_SVH

// Register indices carried in bits 14 to 8 of a control word.
`define ADM_IDX_ATT_LEFT 7'h10
`define ADM_IDX_ATT_RIGHT 7'h11
`define ADM_IDX_MODE_A 7'h12
`define ADM_IDX_MODE_B 7'h13

// Field positions in the format, de-emphasis and mute register.
`define ADM_A_LOAD 7
`define ADM_A_FMT_HI 6
`define ADM_A_FMT_LO 4
`define ADM_A_DMF_HI 3
`define ADM_A_DMF_LO 2
`define ADM_A_DME 1
`define ADM_A_MUTE 0

// Field positions in the output, phase and rate register.
`define ADM_B_PINV 7
`define ADM_B_ATS_HI 6
`define ADM_B_ATS_LO 5
`define ADM_B_ODIS 4
`define ADM_B_STEREO 2

// Reset values and the writable mask of the output register.
`define ADM_ATT_RST 8'hFF
`define ADM_MODE_A_RST 8'h50
`define ADM_MODE_B_RST 8'h00
`define ADM_MODE_B_WMASK 8'hF7

// Highest attenuation code that means full mute.
`define ADM_MUTE_MAX_CODE 8'h0E
// Full-scale code, 0 dB.
`define ADM_FULL_SCALE 8'hFF

`endif

// *** rtl/adm_pkg.sv ***
// Types shared by the mode-control register bank and its helper modules.
// Assumes the constants header is available for numeric values.
package adm_pkg;

    // One 16-bit control word from the host.
    typedef struct packed {
        logic rw;
        logic [6:0] index;
        logic [7:0] data;
    } adm_ctrl_word_t;

    // Serial audio format codes.
    typedef enum logic [2:0] {
        ADM_FMT_RJ16 = 3'h0,
        ADM_FMT_RJ32 = 3'h1,
        ADM_FMT_RJ24 = 3'h2,
        ADM_FMT_LJ24 = 3'h3,
        ADM_FMT_I2S32 = 3'h4,
        ADM_FMT_I2S24 = 3'h5
    } adm_fmt_t;

    // Data justification of the serial input.
    typedef enum logic [1:0] {
        ADM_JUST_RIGHT = 2'h0,
        ADM_JUST_LEFT = 2'h1,
        ADM_JUST_I2S = 2'h2
    } adm_justify_t;

    // Decoded serial format.
    typedef struct packed {
        logic [5:0] word_bits;
        adm_justify_t justify;
        logic [6:0] min_bck_ratio;
    } adm_fmt_dec_t;

    // Decoded state of one channel's attenuator.
    typedef struct packed {
        logic full_mute;
        logic [7:0] atten_half_db;
        logic [7:0] level;
    } adm_chan_t;

endpackage : adm_pkg

// *** rtl/adm_sync3.sv ***
// Three-stage synchroniser for pin inputs with an agreement filter.
// Assumes the input is asynchronous to clock_i.
`timescale 1ns/100ps
module adm_sync3
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic q_ff;

    // The first stage feeds only the second; the output moves once stages two and three agree.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff)
            begin
                q_ff <= s3_ff;
            end
        end
    end

    assign q_o = q_ff;

    // The output only follows a level that two stages have agreed on.
    sync_agree_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (q_ff != $past(q_ff)) |-> ($past(s2_ff) == $past(s3_ff)))
        else $error("synchroniser output moved without agreement");
endmodule : adm_sync3

// *** rtl/adm_atten_ramp.sv ***
// One channel's attenuator level, walked one code per step toward its target.
// Assumes step_en_i is a one-cycle pulse at the selected word-clock rate.
`timescale 1ns/100ps
module adm_atten_ramp
    import adm_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic step_en_i,
    input wire logic [7:0] target_i,
    output logic [7:0] level_o
);
    `include "adm_consts.svh"

    logic [7:0] level_ff;
    logic [7:0] nxt_level;

    // Move one code per step so level changes never click.
    always_comb
    begin
        nxt_level = level_ff;
        if (step_en_i && (level_ff < target_i))
        begin
            nxt_level = level_ff + 8'h01;
        end
        else if (step_en_i && (level_ff > target_i))
        begin
            nxt_level = level_ff - 8'h01;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            level_ff <= `ADM_ATT_RST;
        end
        else
        begin
            level_ff <= nxt_level;
        end
    end

    assign level_o = level_ff;

    // A step while off target moves the level by exactly one code, up or down.
    ramp_one_step_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (step_en_i && (level_ff != target_i)) |=>
        ((level_ff == $past(level_ff) + 8'h01) || (level_ff == $past(level_ff) - 8'h01)))
        else $error("attenuator did not move one code on a step");

    // Without a step the level holds.
    ramp_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !step_en_i |=> $stable(level_ff))
        else $error("attenuator moved without a step");
endmodule : adm_atten_ramp

// *** rtl/adm_mode_regs.sv ***
// Mode-control register bank of a stereo audio converter: attenuation, format,
// de-emphasis, soft mute, phase, output disable and filter-bypass input selection.
// Assumes control words arrive on clock_i from the serial control port logic, and the
// external filter bypass level comes from the system register logic on the same clock.
`timescale 1ns/100ps
module adm_mode_regs
    import adm_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ctrl_valid_i,
    input wire adm_ctrl_word_t ctrl_word_i,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    input wire logic word_select_clock_i,
    input wire logic external_filter_bypass_i,
    input wire logic main_serial_data_i,
    input wire logic left_zero_flag_pin_i,
    input wire logic right_zero_flag_pin_i,
    output adm_chan_t left_chan_o,
    output adm_chan_t right_chan_o,
    output adm_fmt_dec_t format_o,
    output logic deemph_active_o,
    output logic [1:0] deemph_curve_o,
    output logic phase_invert_o,
    output logic output_disable_o,
    output logic bypass_stereo_o,
    output logic bypass_left_data_o,
    output logic bypass_right_data_o
);
    `include "adm_consts.svh"

    logic [7:0] att_left_ff;
    logic [7:0] att_right_ff;
    logic [7:0] applied_left_ff;
    logic [7:0] applied_right_ff;
    logic [7:0] mode_a_ff;
    logic [7:0] mode_b_ff;
    logic rd_valid_ff;
    logic [7:0] rd_data_ff;
    logic wr_stb;
    logic rd_stb;
    logic ws_sync;
    logic main_sync;
    logic zl_sync;
    logic zr_sync;
    logic ws_prev_ff;
    logic [2:0] div_cnt_ff;
    logic step_en_ff;
    logic [2:0] rate_mask;
    logic [7:0] target_left;
    logic [7:0] target_right;
    logic [7:0] level_left;
    logic [7:0] level_right;
    adm_chan_t left_chan_ff;
    adm_chan_t right_chan_ff;
    adm_fmt_dec_t format_ff;
    logic deemph_active_ff;
    logic [1:0] deemph_curve_ff;
    logic phase_invert_ff;
    logic output_disable_ff;
    logic bypass_stereo_ff;
    logic bypass_left_ff;
    logic bypass_right_ff;
    logic load_en;
    logic soft_mute;
    logic bypass_stereo_sel;

    // The top bit of each word chooses write or readback.
    assign wr_stb = ctrl_valid_i && !ctrl_word_i.rw;
    assign rd_stb = ctrl_valid_i && ctrl_word_i.rw;
    assign load_en = mode_a_ff[`ADM_A_LOAD];
    assign soft_mute = mode_a_ff[`ADM_A_MUTE];
    assign bypass_stereo_sel = mode_b_ff[`ADM_B_STEREO];

    // Host-visible registers; only the addressed register changes, and bit 3 of the output register always writes as zero.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            att_left_ff <= `ADM_ATT_RST;
            att_right_ff <= `ADM_ATT_RST;
            mode_a_ff <= `ADM_MODE_A_RST;
            mode_b_ff <= `ADM_MODE_B_RST;
        end
        else if (wr_stb)
        begin
            if (ctrl_word_i.index == `ADM_IDX_ATT_LEFT)
            begin
                att_left_ff <= ctrl_word_i.data;
            end
            else if (ctrl_word_i.index == `ADM_IDX_ATT_RIGHT)
            begin
                att_right_ff <= ctrl_word_i.data;
            end
            else if (ctrl_word_i.index == `ADM_IDX_MODE_A)
            begin
                mode_a_ff <= ctrl_word_i.data;
            end
            else if (ctrl_word_i.index == `ADM_IDX_MODE_B)
            begin
                mode_b_ff <= ctrl_word_i.data & `ADM_MODE_B_WMASK;
            end
        end
    end

    // Levels in use change only on attenuation writes made while loading is enabled.
    // A write with loading disabled is kept for readback but never reaches the attenuator.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            applied_left_ff <= `ADM_ATT_RST;
            applied_right_ff <= `ADM_ATT_RST;
        end
        else if (wr_stb && load_en)
        begin
            if (ctrl_word_i.index == `ADM_IDX_ATT_LEFT)
            begin
                applied_left_ff <= ctrl_word_i.data;
            end
            else if (ctrl_word_i.index == `ADM_IDX_ATT_RIGHT)
            begin
                applied_right_ff <= ctrl_word_i.data;
            end
        end
    end

    // Readback answers one cycle after the request; unmapped indices give zero.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 8'h00;
        end
        else
        begin
            rd_valid_ff <= rd_stb;
            if (rd_stb)
            begin
                if (ctrl_word_i.index == `ADM_IDX_ATT_LEFT)
                begin
                    rd_data_ff <= att_left_ff;
                end
                else if (ctrl_word_i.index == `ADM_IDX_ATT_RIGHT)
                begin
                    rd_data_ff <= att_right_ff;
                end
                else if (ctrl_word_i.index == `ADM_IDX_MODE_A)
                begin
                    rd_data_ff <= mode_a_ff;
                end
                else if (ctrl_word_i.index == `ADM_IDX_MODE_B)
                begin
                    rd_data_ff <= mode_b_ff;
                end
                else
                begin
                    rd_data_ff <= 8'h00;
                end
            end
        end
    end

    // Pins from outside the clock domain.
    adm_sync3 u_sync_ws (.clock_i(clock_i), .rst_n_i(rst_n_i), .d_i(word_select_clock_i), .q_o(ws_sync));
    adm_sync3 u_sync_main (.clock_i(clock_i), .rst_n_i(rst_n_i), .d_i(main_serial_data_i), .q_o(main_sync));
    adm_sync3 u_sync_zl (.clock_i(clock_i), .rst_n_i(rst_n_i), .d_i(left_zero_flag_pin_i), .q_o(zl_sync));
    adm_sync3 u_sync_zr (.clock_i(clock_i), .rst_n_i(rst_n_i), .d_i(right_zero_flag_pin_i), .q_o(zr_sync));

    // Step interval as a mask on the word-clock period counter.
    always_comb
    begin
        case (mode_b_ff[`ADM_B_ATS_HI:`ADM_B_ATS_LO])
            2'h0: rate_mask = 3'h0;
            2'h1: rate_mask = 3'h1;
            2'h2: rate_mask = 3'h3;
            default: rate_mask = 3'h7;
        endcase
    end

    // Count word-clock periods and emit a step pulse once per selected interval.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ws_prev_ff <= 1'b0;
            div_cnt_ff <= 3'h0;
            step_en_ff <= 1'b0;
        end
        else
        begin
            ws_prev_ff <= ws_sync;
            step_en_ff <= 1'b0;
            if (ws_sync && !ws_prev_ff)
            begin
                div_cnt_ff <= div_cnt_ff + 3'h1;
                step_en_ff <= ((div_cnt_ff & rate_mask) == 3'h0);
            end
        end
    end

    // Soft mute drives both channels toward code zero through the same stepper.
    assign target_left = soft_mute ? 8'h00 : applied_left_ff;
    assign target_right = soft_mute ? 8'h00 : applied_right_ff;

    adm_atten_ramp u_ramp_left (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .step_en_i(step_en_ff),
        .target_i(target_left),
        .level_o(level_left)
    );

    adm_atten_ramp u_ramp_right (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .step_en_i(step_en_ff),
        .target_i(target_right),
        .level_o(level_right)
    );

    // Decode each channel's running code into half-dB attenuation and a mute flag.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            left_chan_ff <= '{full_mute: 1'b0, atten_half_db: 8'h00, level: `ADM_ATT_RST};
            right_chan_ff <= '{full_mute: 1'b0, atten_half_db: 8'h00, level: `ADM_ATT_RST};
        end
        else
        begin
            left_chan_ff.level <= level_left;
            left_chan_ff.atten_half_db <= `ADM_FULL_SCALE - level_left;
            left_chan_ff.full_mute <= (level_left <= `ADM_MUTE_MAX_CODE);
            right_chan_ff.level <= level_right;
            right_chan_ff.atten_half_db <= `ADM_FULL_SCALE - level_right;
            right_chan_ff.full_mute <= (level_right <= `ADM_MUTE_MAX_CODE);
        end
    end

    // Format decode; a reserved code leaves the previous decode in force.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            format_ff <= '{word_bits: 6'h18, justify: ADM_JUST_I2S, min_bck_ratio: 7'h30};
        end
        else
        begin
            case (mode_a_ff[`ADM_A_FMT_HI:`ADM_A_FMT_LO])
                ADM_FMT_RJ16: format_ff <= '{6'h10, ADM_JUST_RIGHT, 7'h20};
                ADM_FMT_RJ32: format_ff <= '{6'h20, ADM_JUST_RIGHT, 7'h40};
                ADM_FMT_RJ24: format_ff <= '{6'h18, ADM_JUST_RIGHT, 7'h30};
                ADM_FMT_LJ24: format_ff <= '{6'h18, ADM_JUST_LEFT, 7'h30};
                ADM_FMT_I2S32: format_ff <= '{6'h20, ADM_JUST_I2S, 7'h40};
                ADM_FMT_I2S24: format_ff <= '{6'h18, ADM_JUST_I2S, 7'h30};
                default: format_ff <= format_ff;
            endcase
        end
    end

    // Shared output controls for both channels, and bypass-mode input routing.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            deemph_active_ff <= 1'b0;
            deemph_curve_ff <= 2'h0;
            phase_invert_ff <= 1'b0;
            output_disable_ff <= 1'b0;
            bypass_stereo_ff <= 1'b0;
            bypass_left_ff <= 1'b0;
            bypass_right_ff <= 1'b0;
        end
        else
        begin
            deemph_curve_ff <= mode_a_ff[`ADM_A_DMF_HI:`ADM_A_DMF_LO];
            deemph_active_ff <= mode_a_ff[`ADM_A_DME] &&
                (mode_a_ff[`ADM_A_DMF_HI:`ADM_A_DMF_LO] != 2'h0);
            phase_invert_ff <= mode_b_ff[`ADM_B_PINV];
            output_disable_ff <= mode_b_ff[`ADM_B_ODIS];
            bypass_stereo_ff <= external_filter_bypass_i && bypass_stereo_sel;
            if (!external_filter_bypass_i)
            begin
                bypass_left_ff <= 1'b0;
                bypass_right_ff <= 1'b0;
            end
            else if (bypass_stereo_sel)
            begin
                bypass_left_ff <= zl_sync;
                bypass_right_ff <= zr_sync;
            end
            else
            begin
                bypass_left_ff <= main_sync;
                bypass_right_ff <= main_sync;
            end
        end
    end

    assign rd_valid_o = rd_valid_ff;
    assign rd_data_o = rd_data_ff;
    assign left_chan_o = left_chan_ff;
    assign right_chan_o = right_chan_ff;
    assign format_o = format_ff;
    assign deemph_active_o = deemph_active_ff;
    assign deemph_curve_o = deemph_curve_ff;
    assign phase_invert_o = phase_invert_ff;
    assign output_disable_o = output_disable_ff;
    assign bypass_stereo_o = bypass_stereo_ff;
    assign bypass_left_data_o = bypass_left_ff;
    assign bypass_right_data_o = bypass_right_ff;

    load_blocked_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (wr_stb && !load_en && (ctrl_word_i.index == `ADM_IDX_ATT_LEFT)) |=> $stable(applied_left_ff))
        else $error("attenuation applied while loading disabled");

    load_applied_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (wr_stb && load_en && (ctrl_word_i.index == `ADM_IDX_ATT_RIGHT)) |=>
        (applied_right_ff == $past(ctrl_word_i.data)))
        else $error("attenuation not applied while loading enabled");

    mode_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (wr_stb && (ctrl_word_i.index == `ADM_IDX_MODE_A)) |=> (mode_a_ff == $past(ctrl_word_i.data)))
        else $error("mode register write lost");

    reserved_zero_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (rd_stb && (ctrl_word_i.index == `ADM_IDX_MODE_B)) |=> (rd_valid_o && !rd_data_o[3]))
        else $error("reserved bit read back as one");

    mute_decode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        left_chan_o.full_mute == (left_chan_o.atten_half_db > 8'hF0))
        else $error("mute flag disagrees with attenuation");

    disable_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (wr_stb && (ctrl_word_i.index == `ADM_IDX_MODE_B)) |=> ##1
        (output_disable_o == $past(ctrl_word_i.data[4], 2)))
        else $error("output disable did not follow write");

    bypass_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        bypass_stereo_o |-> $past(external_filter_bypass_i))
        else $error("stereo bypass outside bypass mode");

    step_rate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        step_en_ff |-> ($past(ws_sync) && !$past(ws_prev_ff)))
        else $error("step pulse without word clock edge");
endmodule : adm_mode_regs

// *** bench/adm_host_model.sv ***
// Host controller model that issues control words to the mode-control register bank.
// Assumes the bank takes one word per valid cycle and raises its read answer one cycle later.
`timescale 1ns/100ps
module adm_host_model
    import adm_pkg::*;
(
    input wire logic clock_i,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    output logic ctrl_valid_o,
    output adm_ctrl_word_t ctrl_word_o
);
    // Quiet control port until the first access.
    initial
    begin
        ctrl_valid_o = 1'b0;
        ctrl_word_o = 16'h0000;
    end

    // One access; the word is inverted after use so a stale copy is never read as fresh.
    task automatic xfer(input logic rw, input logic [6:0] idx, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ok);
        int n;
        rdata = 8'h00;
        @(posedge clock_i);
        #1;
        ctrl_valid_o = 1'b1;
        ctrl_word_o = {rw, idx, wdata};
        @(posedge clock_i);
        #1;
        ctrl_valid_o = 1'b0;
        ctrl_word_o = ~ctrl_word_o;
        ok = !rw;
        for (n = 0; n < 3 && !ok; n++)
        begin
            if (rd_valid_i === 1'b1)
            begin
                rdata = rd_data_i;
                ok = 1'b1;
            end
            else
                @(posedge clock_i);
        end
    endtask : xfer
endmodule : adm_host_model

// *** bench/adm_mode_regs_tb_top.sv ***
// Self-checking bench for the mode-control register bank.
// Assumes the host model drives the control port and the bench drives every pin input.
`timescale 1ns/100ps
module adm_mode_regs_tb_top;
    import adm_pkg::*;
    logic clock_i = 1'b0, rst_n_i = 1'b0, ws = 1'b0, efb = 1'b0, sd = 1'b0, zl = 1'b0, zr = 1'b0;
    logic cv, rv, dea, pinv, odis, bst, bl, br;
    logic [7:0] rd;
    logic [1:0] dc;
    adm_ctrl_word_t cw;
    adm_chan_t lc, rc;
    adm_fmt_dec_t fm;
    int err_total = 0, checked = 0;
    logic [7:0] l0, d;
    logic [14:0] ftab [6] = '{{6'd16, 2'd0, 7'd32}, {6'd32, 2'd0, 7'd64}, {6'd24, 2'd0, 7'd48},
                              {6'd24, 2'd1, 7'd48}, {6'd32, 2'd2, 7'd64}, {6'd24, 2'd2, 7'd48}};

    // System clock of 8 ns; the word clock period is 16 system clocks, so 512 cycles hold 32 periods.
    always #4 clock_i = ~clock_i;
    always
    begin
        repeat (8) @(posedge clock_i);
        #1;
        ws = ~ws;
    end

    adm_host_model adm_host_model_inst (.clock_i(clock_i), .rd_valid_i(rv), .rd_data_i(rd),
        .ctrl_valid_o(cv), .ctrl_word_o(cw));
    adm_mode_regs adm_mode_regs_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .ctrl_valid_i(cv),
        .ctrl_word_i(cw), .rd_valid_o(rv), .rd_data_o(rd), .word_select_clock_i(ws),
        .external_filter_bypass_i(efb), .main_serial_data_i(sd), .left_zero_flag_pin_i(zl),
        .right_zero_flag_pin_i(zr), .left_chan_o(lc), .right_chan_o(rc), .format_o(fm),
        .deemph_active_o(dea), .deemph_curve_o(dc), .phase_invert_o(pinv), .output_disable_o(odis),
        .bypass_stereo_o(bst), .bypass_left_data_o(bl), .bypass_right_data_o(br));

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // Compares one seen value with its expectation.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // Register write, and register read compared with its expectation.
    task automatic wr(input logic [6:0] idx, input logic [7:0] wd);
        logic [7:0] x;
        logic ok;
        adm_host_model_inst.xfer(1'b0, idx, wd, x, ok);
        repeat (3) @(posedge clock_i);
        #1;
    endtask : wr

    task automatic rdchk(input logic [6:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        logic ok;
        adm_host_model_inst.xfer(1'b1, idx, 8'h00, x, ok);
        check({15'h0000, ok}, 16'h0001);
        check({8'h00, x}, {8'h00, exp});
    endtask : rdchk

    // Waits, bounded, until both attenuator levels reach the given codes.
    task automatic wait_lv(input logic [7:0] l, input logic [7:0] r);
        int n;
        for (n = 0; n < 9000 && !(lc.level === l && rc.level === r); n++)
        begin
            @(posedge clock_i);
            #1;
        end
        if (n == 9000)
        begin
            err_total++;
            report_and_stop();
        end
    endtask : wait_lv

    // Main sequence: reset, then one test after another.
    initial
    begin
        repeat (5) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        rdchk(7'h10, 8'hFF);
        rdchk(7'h12, 8'h50);
        rdchk(7'h13, 8'h00);
        rdchk(7'h14, 8'h00);
        check({1'h0, fm}, {1'h0, ftab[5]});
        check({12'h000, dea, pinv, odis, bst}, 16'h0000);
        $display("reset test done");
        wr(7'h10, 8'h80);
        repeat (60) @(posedge clock_i);
        #1;
        check({8'h00, lc.level}, 16'h00FF);
        rdchk(7'h10, 8'h80);
        wr(7'h12, 8'hD0);
        wr(7'h10, 8'h10);
        wr(7'h11, 8'h0E);
        wait_lv(8'h10, 8'h0E);
        check({lc.full_mute, lc.atten_half_db}, 16'h00EF);
        check({7'h00, rc.full_mute, rc.atten_half_db}, 16'h01F1);
        $display("attenuation test done");
        wr(7'h10, 8'hFF);
        for (int a = 0; a < 4; a++)
        begin
            wr(7'h13, 8'(a << 5));
            l0 = lc.level;
            repeat (512) @(posedge clock_i);
            #1;
            d = lc.level - l0;
            check({15'h0000, d + 8'h01 >= 8'(32 >> a) && d <= 8'(32 >> a) + 8'h01}, 16'h0001);
        end
        wr(7'h13, 8'h00); // Back to one step per word period so the mute ramp ends inside the wait.
        wr(7'h12, 8'hD1);
        wait_lv(8'h00, 8'h00);
        check({14'h0000, lc.full_mute, rc.full_mute}, 16'h0003);
        wr(7'h12, 8'hD0);
        $display("step and mute test done");
        for (int f = 0; f < 6; f++)
        begin
            wr(7'h12, 8'(f << 4));
            check({1'h0, fm}, {1'h0, ftab[f]});
        end
        for (int m = 0; m < 8; m++)
        begin
            wr(7'h12, 8'h50 | 8'(m << 1));
            check({15'h0000, dea}, {15'h0000, m[0] && m[2:1] != 2'h0});
            if (dea === 1'b1)
                check({14'h0000, dc}, {14'h0000, m[2:1]});
        end
        $display("format and de-emphasis test done");
        wr(7'h13, 8'hFF);
        rdchk(7'h13, 8'hF7);
        check({13'h0000, pinv, odis, bst}, 16'h0006);
        sd = 1'b1;
        zr = 1'b1;
        repeat (8) @(posedge clock_i);
        #1;
        check({14'h0000, bl, br}, 16'h0000);
        efb = 1'b1;
        repeat (8) @(posedge clock_i);
        #1;
        check({13'h0000, bst, bl, br}, 16'h0005);
        wr(7'h13, 8'h00);
        repeat (8) @(posedge clock_i);
        #1;
        check({13'h0000, bst, bl, br}, 16'h0003);
        $display("output and bypass test done");
        report_and_stop();
    end
endmodule : adm_mode_regs_tb_top
